/* File: inc/panel_pkg.sv */
// Constants, codes and carrier types for the front-panel menu controller
package panel_pkg;

	// Clock rate and key timing
	localparam int CLK_MHZ    = 250;
	localparam int TICK_US    = 1000;
	localparam int TICK_CYC   = CLK_MHZ * TICK_US;
	localparam int HOLD_MS    = 1000;
	localparam int HOLD_TICKS = (HOLD_MS * 1000) / TICK_US;

	// Menu limits and special items
	localparam logic [4:0] ITEM_MAX  = 5'h15;
	localparam logic [4:0] ITEM_IN   = 5'h05;
	localparam logic [4:0] ITEM_ENC  = 5'h06;
	localparam logic [4:0] ITEM_OUT  = 5'h07;
	localparam logic [4:0] ITEM_P9   = 5'h09;
	localparam logic [4:0] ITEM_P11  = 5'h0b;
	localparam logic [4:0] ITEM_P13  = 5'h0d;
	localparam logic [3:0] FN_MAX    = 4'hb;
	localparam logic [3:0] FN_ALM    = 4'h0;
	localparam logic [3:0] FN_INIT   = 4'h1;
	localparam logic [3:0] FN_JOG    = 4'h2;
	localparam logic [3:0] FN_AOFS   = 4'h3;
	localparam logic [3:0] FN_MOFS   = 4'h4;
	localparam logic [3:0] FN_ABS0   = 4'ha;
	localparam logic [3:0] ALM_DEPTH = 4'ha;
	localparam logic [1:0] PG_HIGH   = 2'h2;

	// Register byte offsets and fields
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_STAT    = 8'h04;
	localparam logic [7:0] A_OFFS    = 8'h08;
	localparam logic [7:0] A_ALMN    = 8'h0c;
	localparam int         CTRL_ABS  = 0;
	localparam logic       CTRL_RST  = 1'b0;

	// Character codes for the display decoder
	localparam logic [4:0] C_BLANK = 5'h10;
	localparam logic [4:0] C_MINUS = 5'h11;
	localparam logic [4:0] C_N     = 5'h12;
	localparam logic [4:0] C_U     = 5'h13;
	localparam logic [4:0] C_P     = 5'h14;
	localparam logic [4:0] C_F     = 5'h0f;

	// Segment bits: a top, g middle, d bottom, dp
	localparam logic [7:0] SEG_TOP = 8'h01;
	localparam logic [7:0] SEG_BOT = 8'h08;
	localparam logic [7:0] SEG_MID = 8'h40;
	localparam logic [7:0] SEG_DP  = 8'h80;
	localparam logic [7:0] SEG_LB  = 8'h30;
	localparam logic [7:0] SEG_RB  = 8'h06;

	typedef enum logic [9:0] {
		S_STATUS = 10'h001,
		S_PARAM  = 10'h002,
		S_MSEL   = 10'h004,
		S_MVAL   = 10'h008,
		S_FSEL   = 10'h010,
		S_ALM    = 10'h020,
		S_INIT   = 10'h040,
		S_JOG    = 10'h080,
		S_AOFS   = 10'h100,
		S_FVIEW  = 10'h200
	} mode_e;

	// Input signal monitor bits, bit 0 is servo-on
	typedef struct packed {
		logic reverse_limit_input;
		logic forward_limit_input;
		logic counter_clear_input;
		logic alarm_reset_input;
		logic reverse_overtravel_input;
		logic forward_overtravel_input;
		logic proportional_ctrl_input;
		logic servo_on_input;
	} in_sig_s;

	typedef struct packed {
		logic mode;
		logic enter;
		logic inc;
		logic dec;
	} keys_s;

	// Monitor value as sign and eleven decimal digits
	typedef struct packed {
		logic             neg;
		logic [10:0][3:0] bcd;
	} mon_s;

	typedef logic [4:0][7:0] disp_t;

endpackage : panel_pkg

/* File: rtl/panel_menu.sv */
// Front-panel menu controller: keys, monitor and utility menus, display
// Behaviour
// - Mode key cycles the four basic modes
// - Status display mode after reset
// - Monitor: step items, enter toggles value view
// - Monitor items numbered zero to twenty-one
// - Input monitor shows eight signal bits
// - Long counts shown over three pages
// - Fifth digit segment marks current page
// - Negative: fifth dp, page three minus
// - Up and down keys switch pages
// - Utility functions numbered zero to eleven
// - Functions ten, eleven need absolute encoder
// - Ten alarm history entries, browse, exit
// - Hold enter one second erases history
// - Hold enter one second initializes parameters
// - Initialization refused while servo on
// - Jog: mode toggles servo, keys rotate
// - Leaving jog forces servo off
// - Hold mode one second adjusts offset
// - Adjusted offset kept, shown in function four
// - Offset adjust only with servo off
module panel_menu
	import panel_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire keys_s       keys,
	input  wire in_sig_s     in_sig,
	input  wire logic [2:0]  enc_phase,
	input  wire logic [3:0]  out_sig,
	input  wire mon_s        mon,
	input  wire logic        alarm_evt,
	input  wire logic [7:0]  alarm_code,
	input  wire logic [15:0] ofs_meas,
	output logic [4:0]       mon_item,
	output disp_t            disp,
	output logic             servo_cmd,
	output logic             jog_fwd,
	output logic             jog_rev,
	output logic             param_init,
	output logic             ofs_adjust,
	output logic [15:0]      ref_offset
);

	////////////////////////////////////////////////////////////////////////
	// State record

	typedef struct packed {
		mode_e           mode;
		logic [4:0]      item;
		logic [3:0]      fn;
		logic [1:0]      page;
		logic            servo;
		logic [9:0][7:0] almq;
		logic [3:0]      alm_n;
		logic [3:0]      alm_i;
		logic [15:0]     offset;
		logic            abs_enc;
		logic            wpend;
		logic [7:0]      waddr;
		logic [31:0]     rdata;
		disp_t           disp;
		logic            jf;
		logic            jr;
		logic            init_p;
		logic            ofs_p;
		logic [17:0]     tdiv;
		keys_s           samp;
		keys_s           stab;
		keys_s           prev;
		logic [9:0]      hold;
		logic            long_done;
	} st_s;

	st_s s_q;
	st_s s_d;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Character code to segments, dp off
	function automatic logic [7:0] seg(input logic [4:0] c);
		unique case (c)
			5'h00: seg = 8'h3f;
			5'h01: seg = 8'h06;
			5'h02: seg = 8'h5b;
			5'h03: seg = 8'h4f;
			5'h04: seg = 8'h66;
			5'h05: seg = 8'h6d;
			5'h06: seg = 8'h7d;
			5'h07: seg = 8'h07;
			5'h08: seg = 8'h7f;
			5'h09: seg = 8'h6f;
			5'h0a: seg = 8'h77;
			5'h0b: seg = 8'h7c;
			5'h0c: seg = 8'h39;
			5'h0d: seg = 8'h5e;
			5'h0e: seg = 8'h79;
			5'h0f: seg = 8'h71;
			5'h11: seg = 8'h40;
			5'h12: seg = 8'h54;
			5'h13: seg = 8'h3e;
			5'h14: seg = 8'h73;
			default: seg = 8'h00;
		endcase
	endfunction : seg

	// Five-digit label: two letters, then a number up to 29
	function automatic disp_t label(input logic [4:0] a, input logic [4:0] b, input logic [4:0] v);
		logic [4:0] t;
		t = (v >= 5'h14) ? 5'h02 : (v >= 5'h0a) ? 5'h01 : 5'h00;
		label = {seg(a), seg(b), seg(5'h00), seg(t), seg(5'(v - 5'(t * 5'h0a)))};
	endfunction : label

	// Step a value up or down between zero and a limit
	function automatic logic [4:0] step(input logic [4:0] v, input logic [4:0] mx, input logic up);
		if (up) begin
			step = (v == mx) ? v : 5'(v + 5'h01);
		end else begin
			step = (v == 5'h00) ? v : 5'(v - 5'h01);
		end
	endfunction : step

	function automatic logic multi(input logic [4:0] i);
		multi = (i == ITEM_P9) || (i == ITEM_P11) || (i == ITEM_P13);
	endfunction : multi

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic       tick;
		logic       any_held;
		logic       long_ev;
		logic       ent_s;
		keys_s      pr;
		logic       srv_on;
		logic [7:0] bits;
		logic [4:0] ni;
		ni = 5'h00;
		bits = 8'h00;
		s_d = s_q;
		s_d.init_p = 1'b0;
		s_d.ofs_p = 1'b0;

		tick = (s_q.tdiv == 18'(TICK_CYCLES - 1));
		s_d.tdiv = tick ? 18'h00000 : 18'(s_q.tdiv + 18'h00001);
		if (tick) begin
			s_d.samp = keys;
			s_d.stab = (keys == s_q.samp) ? keys : s_q.stab;
		end
		s_d.prev = s_q.stab;
		pr = s_q.stab & ~s_q.prev;

		// hold timing for enter and mode
		any_held = s_q.stab.enter | s_q.stab.mode;
		long_ev = tick && any_held && (s_q.hold == 10'(HOLD_TICKS - 1));
		if (!any_held) begin
			s_d.hold = 10'h000;
		end else if (tick && (s_q.hold != 10'(HOLD_TICKS))) begin
			s_d.hold = 10'(s_q.hold + 10'h001);
		end
		if (long_ev) begin
			s_d.long_done = 1'b1;
		end else if (!any_held) begin
			s_d.long_done = 1'b0;
		end
		// Enter acts on release so a long hold is not also a short press
		ent_s = s_q.prev.enter && !s_q.stab.enter && !s_q.long_done;

		srv_on = in_sig.servo_on_input | s_q.servo;

		unique case (s_q.mode)
			S_STATUS: begin
				if (pr.mode) s_d.mode = S_PARAM;
			end
			S_PARAM: begin
				if (pr.mode) s_d.mode = S_MSEL;
			end
			S_MSEL: begin
				if (pr.mode) begin
					s_d.mode = S_FSEL;
				end else if (ent_s) begin
					s_d.mode = S_MVAL;
					s_d.page = 2'h0;
				end else if (pr.inc || pr.dec) begin
					ni = step(s_q.item, ITEM_MAX, pr.inc);
					if (ni == 5'h0a || ni == 5'h0c || ni == 5'h0e) begin
						ni = step(ni, ITEM_MAX, pr.inc);
					end
					s_d.item = ni;
				end
			end
			S_MVAL: begin
				if (ent_s) s_d.mode = S_MSEL;
				if (multi(s_q.item) && pr.inc && s_q.page != PG_HIGH) s_d.page = 2'(s_q.page + 2'h1);
				if (multi(s_q.item) && pr.dec && s_q.page != 2'h0) s_d.page = 2'(s_q.page - 2'h1);
			end
			S_FSEL: begin
				if (pr.mode) begin
					s_d.mode = S_STATUS;
				end else if (pr.inc || pr.dec) begin
					s_d.fn = 4'(step(5'(s_q.fn), 5'(FN_MAX), pr.inc));
				end else if (ent_s) begin
					s_d.alm_i = 4'h0;
					unique case (s_q.fn)
						FN_ALM: s_d.mode = S_ALM;
						FN_INIT: s_d.mode = S_INIT;
						FN_JOG: s_d.mode = S_JOG;
						FN_AOFS: s_d.mode = S_AOFS;
						default: if (s_q.fn < FN_ABS0 || s_q.abs_enc) s_d.mode = S_FVIEW;
					endcase
				end
			end
			S_ALM: begin
				if (ent_s) s_d.mode = S_FSEL;
				if (pr.inc && s_q.alm_i + 4'h1 < s_q.alm_n) s_d.alm_i = 4'(s_q.alm_i + 4'h1);
				if (pr.dec && s_q.alm_i != 4'h0) s_d.alm_i = 4'(s_q.alm_i - 4'h1);
				if (long_ev && s_q.stab.enter && s_q.alm_n != 4'h0) begin
					s_d.alm_n = 4'h0;
					s_d.alm_i = 4'h0;
				end
			end
			S_INIT: begin
				if (long_ev && s_q.stab.enter && !srv_on) s_d.init_p = 1'b1;
				if (s_q.prev.enter && !s_q.stab.enter) s_d.mode = S_FSEL;
			end
			S_JOG: begin
				if (pr.mode) s_d.servo = !s_q.servo;
				if (ent_s) begin
					s_d.mode = S_FSEL;
					s_d.servo = 1'b0;
				end
			end
			S_AOFS: begin
				if (long_ev && s_q.stab.mode && !srv_on) begin
					s_d.ofs_p = 1'b1;
					s_d.offset = ofs_meas;
				end
				if (ent_s) s_d.mode = S_FSEL;
			end
			S_FVIEW: begin
				if (ent_s) s_d.mode = S_FSEL;
			end
		endcase

		s_d.jf = (s_d.mode == S_JOG) && s_d.servo && s_q.stab.inc;
		s_d.jr = (s_d.mode == S_JOG) && s_d.servo && s_q.stab.dec && !s_q.stab.inc;

		// newest alarm pushed last so it survives a same-cycle erase
		if (alarm_evt) begin
			s_d.almq = {s_q.almq[8:0], alarm_code};
			if (s_d.alm_n != ALM_DEPTH) s_d.alm_n = 4'(s_d.alm_n + 4'h1);
		end

		// Bus slave: zero wait, write lands in the data phase
		if (s_q.wpend && hready && s_q.waddr == A_CTRL) s_d.abs_enc = hwdata[CTRL_ABS];
		if (hready) begin
			s_d.wpend = hsel && htrans[1] && hwrite;
			s_d.waddr = haddr[7:0];
			unique case (haddr[7:0])
				A_CTRL: s_d.rdata = {31'h00000000, s_d.abs_enc};
				A_STAT: s_d.rdata = {6'h00, s_q.mode, s_q.servo, s_q.page, s_q.fn, 4'h0, s_q.item};
				A_OFFS: s_d.rdata = {16'h0000, s_q.offset};
				A_ALMN: s_d.rdata = {28'h0000000, s_q.alm_n};
				default: s_d.rdata = 32'h00000000;
			endcase
		end

		// Display picture for the new state
		unique case (s_d.item)
			ITEM_IN: bits = in_sig;
			ITEM_ENC: bits = {2'h0, enc_phase, 3'h0};
			ITEM_OUT: bits = {4'h0, out_sig};
			default: bits = 8'h00;
		endcase
		unique case (s_d.mode)
			S_STATUS: s_d.disp = {5{seg(C_MINUS)}};
			S_PARAM: s_d.disp = {seg(C_P), seg(C_N), {3{seg(C_BLANK)}}};
			S_MSEL: s_d.disp = label(C_U, C_N, s_d.item);
			S_MVAL: begin
				if (s_d.item == ITEM_IN || s_d.item == ITEM_ENC || s_d.item == ITEM_OUT) begin
					// bit view, bit 0 rightmost, two bars per digit
					s_d.disp[4] = 8'h00;
					for (int k = 0; k < 4; k++) begin
						s_d.disp[k] = (bits[2*k] ? SEG_RB : 8'h00) | (bits[2*k+1] ? SEG_LB : 8'h00);
					end
				end else if (multi(s_d.item)) begin
					unique case (s_d.page)
						2'h0: s_d.disp[3:0] = {seg(5'(mon.bcd[3])), seg(5'(mon.bcd[2])),
							seg(5'(mon.bcd[1])), seg(5'(mon.bcd[0]))};
						2'h1: s_d.disp[3:0] = {seg(5'(mon.bcd[7])), seg(5'(mon.bcd[6])),
							seg(5'(mon.bcd[5])), seg(5'(mon.bcd[4]))};
						default: s_d.disp[3:0] = {seg(mon.neg ? C_MINUS : C_BLANK),
							seg(5'(mon.bcd[10])), seg(5'(mon.bcd[9])), seg(5'(mon.bcd[8]))};
					endcase
					s_d.disp[4] = (s_d.page == 2'h0) ? SEG_BOT : (s_d.page == 2'h1) ? SEG_MID : SEG_TOP;
					if (mon.neg) s_d.disp[4] = s_d.disp[4] | SEG_DP;
				end else begin
					// plain value, sign in the fifth digit
					s_d.disp = {seg(mon.neg ? C_MINUS : 5'(mon.bcd[4])), seg(5'(mon.bcd[3])),
						seg(5'(mon.bcd[2])), seg(5'(mon.bcd[1])), seg(5'(mon.bcd[0]))};
				end
			end
			S_ALM: begin
				if (s_d.alm_n == 4'h0) begin
					s_d.disp = {5{seg(C_MINUS)}};
				end else begin
					s_d.disp = {seg(5'(s_d.alm_i)), seg(C_BLANK), seg(C_BLANK),
						seg(5'(s_d.almq[s_d.alm_i][7:4])), seg(5'(s_d.almq[s_d.alm_i][3:0]))};
				end
			end
			default: begin
				// Function select and entered function views
				s_d.disp = label(C_F, C_N, 5'(s_d.fn)) | {SEG_DP, 32'h00000000};
				if (s_d.mode == S_FVIEW && s_d.fn == FN_MOFS) begin
					s_d.disp = {seg(s_d.offset[15] ? C_MINUS : C_BLANK),
						seg(5'(s_d.offset[15:12])), seg(5'(s_d.offset[11:8])),
						seg(5'(s_d.offset[7:4])), seg(5'(s_d.offset[3:0]))};
				end
				if (s_d.mode == S_JOG && s_d.servo) s_d.disp[0] = s_d.disp[0] | SEG_DP;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.mode <= S_STATUS;
			s_q.abs_enc <= CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Bus answers OKAY with no wait states
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = s_q.rdata;
	assign mon_item   = s_q.item;
	assign disp       = s_q.disp;
	assign servo_cmd  = s_q.servo;
	assign jog_fwd    = s_q.jf;
	assign jog_rev    = s_q.jr;
	assign param_init = s_q.init_p;
	assign ofs_adjust = s_q.ofs_p;
	assign ref_offset = s_q.offset;

endmodule : panel_menu

/* File: tb/panel_menu_assertions.sv */
// Port checker for the panel menu controller
module panel_menu_assertions
	import panel_pkg::*;
#(
	parameter int TICK_CYCLES = 4
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire keys_s       keys,
	input wire in_sig_s     in_sig,
	input wire logic [15:0] ofs_meas,
	input wire logic [4:0]  mon_item,
	input wire logic        servo_cmd,
	input wire logic        jog_fwd,
	input wire logic        jog_rev,
	input wire logic        param_init,
	input wire logic        ofs_adjust,
	input wire logic [15:0] ref_offset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Debounce slack: two ticks under, four ticks over the hold
	localparam int LO = (HOLD_TICKS - 2) * TICK_CYCLES;
	localparam int HI = (HOLD_TICKS + 4) * TICK_CYCLES;
	int ent_n;
	int mod_n;
	////////////////////////////////////////////////////////////////
	// Held-key cycle counts, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ent_n <= 0;
			mod_n <= 0;
		end else begin
			ent_n <= keys.enter ? ((ent_n < HI) ? ent_n + 1 : ent_n) : 0;
			mod_n <= keys.mode ? ((mod_n < HI) ? mod_n + 1 : mod_n) : 0;
		end
	end
	sequence pulse_s(x);
		x ##1 !x;
	endsequence
	////////////////////////////////////////////////////////////////
	// one second hold, single-cycle pulses, servo interlock, offset, jog and item range
	init_hold_a: assert property (param_init |-> ent_n >= LO && ent_n <= HI)
		else $error("init pulse not after a one second hold");
	init_pulse_a: assert property (param_init |-> pulse_s(param_init))
		else $error("init pulse longer than one cycle");
	init_servo_a: assert property (param_init |-> !$past(in_sig.servo_on_input) && !$past(servo_cmd))
		else $error("init with servo on");
	adj_hold_a: assert property (ofs_adjust |-> mod_n >= LO && mod_n <= HI)
		else $error("adjust not after a one second hold");
	adj_pulse_a: assert property (ofs_adjust |-> pulse_s(ofs_adjust))
		else $error("adjust pulse longer than one cycle");
	adj_servo_a: assert property (ofs_adjust |-> !$past(in_sig.servo_on_input) && !servo_cmd)
		else $error("adjust with servo on");
	ofs_keep_a: assert property ($changed(ref_offset) |-> ofs_adjust || $past(ofs_adjust))
		else $error("offset changed without adjust");
	ofs_value_a: assert property (ofs_adjust |-> ##[0:2] ref_offset == ofs_meas)
		else $error("offset not taken from measurement");
	jog_servo_a: assert property ((jog_fwd || jog_rev) |-> servo_cmd)
		else $error("jog with servo off");
	item_range_a: assert property (mon_item <= ITEM_MAX && !(mon_item inside {5'h0a, 5'h0c, 5'h0e}))
		else $error("monitor item out of list");
endmodule : panel_menu_assertions

bind panel_menu panel_menu_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (.hclk, .hresetn, .keys, .in_sig,
	.ofs_meas, .mon_item, .servo_cmd, .jog_fwd, .jog_rev, .param_init, .ofs_adjust, .ref_offset);

/* File: tb/keypad_model.sv */
// Operator keypad model driving the four panel keys
module keypad_model
	import panel_pkg::*;
(
	input wire logic hclk,
	output keys_s    keys
);
	timeunit 1ns;
	timeprecision 1ps;
	initial keys = '0;
	////////////////////////////////////////////////////////////////
	// Press a key after an edge and keep it down n cycles
	task automatic hold(input int k, input int n);
		@(posedge hclk);
		keys[k] <= 1'b1;
		repeat (n) @(posedge hclk);
	endtask : hold
	// Release; the idle gap spans ten ticks so the debouncer settles
	task automatic rel(input int k);
		keys[k] <= 1'b0;
		repeat (40) @(posedge hclk);
	endtask : rel
	task automatic push(input int k, input int n);
		hold(k, n);
		rel(k);
	endtask : push
endmodule : keypad_model

/* File: tb/tb_top.sv */
// Self-checking bench for the panel menu controller
module tb_top
	import panel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	localparam int LG = (HOLD_TICKS + 50) * TK;
	localparam int KM = 3, KE = 2, KI = 1, KD = 0;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic        hreadyout, hresp, servo_cmd, jog_fwd, jog_rev, param_init, ofs_adjust;
	logic [31:0] hrdata, rd;
	keys_s       keys;
	in_sig_s     in_sig = 8'ha6;
	logic [2:0]  enc_phase = 3'h5;
	logic [3:0]  out_sig = 4'ha;
	mon_s        mon = {1'b1, 44'h12147483648};
	logic        alarm_evt = 1'b0;
	logic [7:0]  alarm_code = '0;
	logic [15:0] ofs_meas = '0;
	logic [15:0] ref_offset;
	logic [4:0]  mon_item;
	disp_t       disp;
	mode_e       seq[4] = '{S_PARAM, S_MSEL, S_FSEL, S_STATUS};
	logic [7:0]  mark[4] = '{SEG_BOT, SEG_MID, SEG_TOP, SEG_TOP};
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          n_init = 0;
	int          n_adj = 0;
	////////////////////////////////////////////////////////////////
	panel_menu #(.TICK_CYCLES(TK)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .keys, .in_sig, .enc_phase, .out_sig, .mon,
		.alarm_evt, .alarm_code, .ofs_meas, .mon_item, .disp, .servo_cmd, .jog_fwd, .jog_rev,
		.param_init, .ofs_adjust, .ref_offset);
	keypad_model kp (.hclk, .keys);
	always #2 hclk = ~hclk;
	// Count action pulses
	always @(posedge hclk) begin
		n_init <= n_init + (param_init === 1'b1);
		n_adj <= n_adj + (ofs_adjust === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait for ready at an edge
	task automatic rdy();
		int i;
		for (i = 0; i < 16; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1) break;
		end
		if (i == 16) begin
			n_mismatch++;
			test_done();
		end
	endtask : rdy
	// One single word transfer; read data lands in rd
	// Select stays up afterwards so back-to-back calls never drive it twice in one step
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask : bus
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask : rc
	task automatic st(input mode_e m);
		bus(A_STAT, 1'b0, 32'h0);
		chk("mode", {22'h0, m}, {22'h0, rd[25:16]});
	endtask : st
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		st(S_STATUS);
		chk("dashes", 32'h40404040, {disp[3], disp[2], disp[1], disp[0]});
		rc(A_CTRL, 32'h0, "ctrl");
		rc(8'h10, 32'h0, "unmapped");
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
		foreach (seq[i]) begin
			kp.push(KM, 40);
			st(seq[i]);
		end
		kp.push(KM, 40);
		kp.push(KM, 40);
		// a one-cycle glitch must not step the item
		kp.push(KI, 1);
		chk("glitch", 32'h0, {27'h0, mon_item});
		repeat (5) kp.push(KI, 40);
		chk("item", 32'h5, {27'h0, mon_item});
		kp.push(KE, 40);
		st(S_MVAL);
		chk("bits", 32'h30300630, {disp[3], disp[2], disp[1], disp[0]} & 32'h36363636);
		kp.push(KE, 40);
		st(S_MSEL);
		// encoder and output bit views on the way to the paged item
		kp.push(KI, 40);
		kp.push(KE, 40);
		chk("enc", 32'h00303000, {disp[3], disp[2], disp[1], disp[0]});
		kp.push(KE, 40);
		kp.push(KI, 40);
		kp.push(KE, 40);
		chk("out", 32'h00003030, {disp[3], disp[2], disp[1], disp[0]});
		kp.push(KE, 40);
		repeat (2) kp.push(KI, 40);
		chk("item", {27'h0, ITEM_P9}, {27'h0, mon_item});
		kp.push(KE, 40);
		chk("page0", 32'h4f7d667f, {disp[3], disp[2], disp[1], disp[0]});
		for (int p = 0; p < 4; p++) begin
			bus(A_STAT, 1'b0, 32'h0);
			chk("page", (p > 2) ? 2 : p, {30'h0, rd[14:13]});
			chk("mark", {24'h0, mark[p] | SEG_DP}, {24'h0, disp[4] & 8'hc9});
			kp.push(KI, 40);
		end
		chk("minus", 32'h40, {24'h0, disp[3]});
		mon.neg <= 1'b0;
		repeat (8) @(posedge hclk);
		chk("dp", 32'h0, {31'h0, disp[4][7]});
		kp.push(KE, 40);
		kp.push(KM, 40);
		st(S_FSEL);
		for (int i = 1; i < 13; i++) begin
			alarm_evt <= 1'b1;
			alarm_code <= 8'(i);
			@(posedge hclk);
			alarm_evt <= 1'b0;
			@(posedge hclk);
		end
		rc(A_ALMN, 32'ha, "alarms");
		kp.push(KE, 40);
		st(S_ALM);
		kp.push(KE, LG);
		rc(A_ALMN, 32'h0, "alarms");
		kp.push(KE, 40);
		st(S_FSEL);
		kp.push(KI, 40);
		kp.push(KE, 40);
		st(S_INIT);
		in_sig <= 8'ha7;
		kp.push(KE, LG);
		chk("init", 32'h0, n_init);
		bus(A_STAT, 1'b0, 32'h0);
		if (rd[25:16] !== S_INIT) kp.push(KE, 40);
		in_sig <= 8'ha6;
		kp.push(KE, LG);
		chk("init", 32'h1, n_init);
		st(S_FSEL);
		kp.push(KI, 40);
		kp.push(KE, 40);
		st(S_JOG);
		for (int j = 0; j < 3; j++) begin
			kp.push(KM, 40);
			chk("servo", 32'(j != 1), {31'h0, servo_cmd});
			kp.hold(KI, 40);
			chk("fwd", 32'(j != 1), {31'h0, jog_fwd});
			kp.rel(KI);
			kp.hold(KD, 40);
			chk("rev", 32'(j != 1), {31'h0, jog_rev});
			kp.rel(KD);
		end
		kp.push(KE, 40);
		st(S_FSEL);
		chk("servo", 32'h0, {31'h0, servo_cmd});
		kp.push(KI, 40);
		kp.push(KE, 40);
		st(S_AOFS);
		ofs_meas <= 16'h1a2b;
		in_sig <= 8'ha7;
		kp.push(KM, LG);
		chk("adjust", 32'h0, n_adj);
		in_sig <= 8'ha6;
		kp.push(KM, LG);
		chk("adjust", 32'h1, n_adj);
		rc(A_OFFS, 32'h1a2b, "offset");
		chk("ref_offset", 32'h1a2b, {16'h0, ref_offset});
		kp.push(KE, 40);
		st(S_FSEL);
		repeat (8) kp.push(KI, 40);
		bus(A_STAT, 1'b0, 32'h0);
		chk("fn", {28'h0, FN_MAX}, {28'h0, rd[12:9]});
		kp.push(KE, 40);
		st(S_FSEL);
		bus(A_CTRL, 1'b1, 32'h1);
		rc(A_CTRL, 32'h1, "ctrl");
		kp.push(KE, 40);
		st(S_FVIEW);
		test_done();
	end
endmodule : tb_top
